// file: hdl/mpf_pkg.sv
/*
  Package for the miscellaneous pin function selector: strap sampling
  timing, power-override encodings and grouped pin carriers.
  Assumes a single 50 MHz clock domain and no register bus.
*/
package mpf_pkg;

  // Number of general-purpose pins handled by the selector (pins 0..5)
  localparam int MPF_NUM_GP = 6;

  // Direction bit positions
  localparam int MPF_DIR_BIT_ZERO  = 0;
  localparam int MPF_DIR_BIT_ONE   = 1;
  localparam int MPF_DIR_BIT_TWO   = 2;
  localparam int MPF_DIR_BIT_THREE = 3;

  // Power-override field position in the general control word
  localparam int MPF_PWR_FIELD_LSB = 20;
  localparam int MPF_PWR_FIELD_MSB = 22;

  // Power-override codes that claim pin one
  localparam logic [2:0] MPF_PWR_CODE_A = 3'h1;
  localparam logic [2:0] MPF_PWR_CODE_B = 3'h3;

  // Strap values after reset (internal pulldowns)
  localparam logic MPF_STRAP_RST = 1'b0;

  // Cycles after fundamental reset release before straps are latched
  localparam logic [1:0] MPF_SAMPLE_DELAY = 2'h2;

  // Pin function state captured at reset release
  typedef struct packed {
    logic clock_stop_en;     // Clock-run support enabled
    logic outside_arbiter;   // External arbiter selected
    logic compat_mode;       // Compatibility mode enabled
    logic serial_bus_mode;   // Serial bus owns pins four and five
  } mpf_straps_t;

  // One shared pin as seen by the core: drive value and enable
  typedef struct packed {
    logic out;
    logic oe;
  } mpf_pin_drive_t;

endpackage

// file: hdl/mpf_strap_latch.sv
/*
  Strap latch: catches strap levels once the fundamental reset has been
  released and holds them until the next reset.
  Assumes strap inputs are stable around reset release.
*/
`timescale 1ns/1ns
module mpf_strap_latch
  import mpf_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        fundamental_reset_n,
  // Raw strap levels
  input  wire mpf_straps_t raw_straps,
  // Latched result
  output mpf_straps_t      straps_q,
  output logic             straps_valid_q
);

  logic [1:0] wait_q;
  logic       sample;

  // Latch once the delay expires after fundamental reset release
  assign sample = fundamental_reset_n && !straps_valid_q && (wait_q == MPF_SAMPLE_DELAY);

  // Delay counter runs only while reset is released and straps not taken
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_q <= 2'h0;
    end else if (!fundamental_reset_n) begin
      wait_q <= 2'h0;
    end else if (!straps_valid_q && wait_q != MPF_SAMPLE_DELAY) begin
      wait_q <= wait_q + 2'h1;
    end
  end

  // Capture straps once the delay expires after release and hold until next reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      straps_q       <= '0;
      straps_valid_q <= 1'b0;
    end else if (!fundamental_reset_n) begin
      straps_q       <= '0;
      straps_valid_q <= 1'b0;
    end else if (sample) begin
      straps_q       <= raw_straps;
      straps_valid_q <= 1'b1;
    end
  end

endmodule

// file: hdl/mpf_pin_select.sv
/*
  Miscellaneous pin function selector: routes shared terminals to GPIO,
  clock-stop request, power override or two-wire serial bus functions.
  Assumes synchronous pin inputs and a single clock; pads resolve the
  output enables externally.
*/
`timescale 1ns/1ns
module mpf_pin_select
  import mpf_pkg::*;
#(
  parameter int NUM_GP = MPF_NUM_GP
) (
  // Clock and resets
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              fundamental_reset_n,
  // Straps
  input  wire logic              clock_stop_support_strap,
  input  wire logic              outside_arbiter_strap,
  // Core controls
  input  wire logic [NUM_GP-1:0] gp_direction,
  input  wire logic [NUM_GP-1:0] gp_out_value,
  input  wire logic [2:0]        power_override_field,
  input  wire logic              power_override_value,
  input  wire logic              serial_clock_oe_core,
  input  wire logic              serial_data_oe_core,
  input  wire logic              arb_request_core,
  // Pads of the shared pins: 0..3 GPIO, 4 clock, 5 data
  input  wire logic [NUM_GP-1:0] gp_pin_in,
  output logic [NUM_GP-1:0]      gp_pin_out,
  output logic [NUM_GP-1:0]      gp_pin_oe,
  // Arbitration pins in external arbiter mode
  input  wire logic              req_zero_in,
  output logic                   gnt_zero_out,
  // Status to the core
  output logic [NUM_GP-1:0]      gp_in_value,
  output logic                   clock_stop_enabled,
  output logic                   outside_arbiter_sel,
  output logic                   compat_mode,
  output logic                   serial_bus_mode,
  output logic                   clock_stop_request,
  output logic                   power_override_active,
  output logic                   serial_clock_in,
  output logic                   serial_data_in,
  output logic                   arb_grant_core
);

  mpf_straps_t    raw_straps;
  mpf_straps_t    straps;
  logic           straps_valid;
  logic           pwr_sel;
  mpf_pin_drive_t drv_d [NUM_GP];

  // Gather raw strap levels for the latch
  assign raw_straps.clock_stop_en   = clock_stop_support_strap;
  assign raw_straps.outside_arbiter = outside_arbiter_strap;
  assign raw_straps.compat_mode     = gp_pin_in[MPF_DIR_BIT_TWO];
  assign raw_straps.serial_bus_mode = gp_pin_in[5];

  mpf_strap_latch u_latch (
    .mclk                (mclk),
    .rst                 (rst),
    .fundamental_reset_n (fundamental_reset_n),
    .raw_straps          (raw_straps),
    .straps_q            (straps),
    .straps_valid_q      (straps_valid)
  );

  // Power override owns pin one for two codes only
  assign pwr_sel = (power_override_field == MPF_PWR_CODE_A) ||
                   (power_override_field == MPF_PWR_CODE_B);

  // Per-pin drive selection
  genvar g;
  generate
    for (g = 0; g < NUM_GP; g++) begin : g_pin
      if (g == 0) begin : g_zero
        // Clock-stop request is an input only in clock-run mode
        assign drv_d[g].oe  = straps.clock_stop_en ? 1'b0 : gp_direction[g];
        assign drv_d[g].out = gp_out_value[g];
      end else if (g == 1) begin : g_one
        assign drv_d[g].oe  = pwr_sel ? 1'b1 : gp_direction[g];
        assign drv_d[g].out = pwr_sel ? power_override_value : gp_out_value[g];
      end else if (g == 4) begin : g_four
        // Serial clock is open drain: drive low only
        assign drv_d[g].oe  = straps.serial_bus_mode ? serial_clock_oe_core
                                                     : gp_direction[g];
        assign drv_d[g].out = straps.serial_bus_mode ? 1'b0 : gp_out_value[g];
      end else if (g == 5) begin : g_five
        assign drv_d[g].oe  = straps.serial_bus_mode ? serial_data_oe_core
                                                     : gp_direction[g];
        assign drv_d[g].out = straps.serial_bus_mode ? 1'b0 : gp_out_value[g];
      end else begin : g_plain
        // Pins two and three are plain GPIO
        assign drv_d[g].oe  = gp_direction[g];
        assign drv_d[g].out = gp_out_value[g];
      end

      // Registered pad drive; nothing driven before straps are known
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          gp_pin_oe[g]  <= 1'b0;
          gp_pin_out[g] <= 1'b0;
        end else begin
          gp_pin_oe[g]  <= straps_valid && drv_d[g].oe;
          gp_pin_out[g] <= drv_d[g].out;
        end
      end
    end
  endgenerate

  // Registered status and function inputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gp_in_value           <= '0;
      clock_stop_enabled    <= MPF_STRAP_RST;
      outside_arbiter_sel   <= MPF_STRAP_RST;
      compat_mode           <= 1'b0;
      serial_bus_mode       <= 1'b0;
      clock_stop_request    <= 1'b0;
      power_override_active <= 1'b0;
      serial_clock_in       <= 1'b1;
      serial_data_in        <= 1'b1;
    end else begin
      gp_in_value           <= gp_pin_in;
      clock_stop_enabled    <= straps.clock_stop_en;
      outside_arbiter_sel   <= straps.outside_arbiter;
      compat_mode           <= straps.compat_mode;
      serial_bus_mode       <= straps.serial_bus_mode;
      clock_stop_request    <= straps.clock_stop_en && gp_pin_in[0];
      power_override_active <= pwr_sel;
      serial_clock_in       <= straps.serial_bus_mode ? gp_pin_in[4] : 1'b1;
      serial_data_in        <= straps.serial_bus_mode ? gp_pin_in[5] : 1'b1;
    end
  end

  // External arbiter hookup: request on grant zero, grant from request zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gnt_zero_out   <= 1'b1;
      arb_grant_core <= 1'b0;
    end else begin
      gnt_zero_out   <= straps.outside_arbiter ? ~arb_request_core : 1'b1;
      arb_grant_core <= straps.outside_arbiter && !req_zero_in;
    end
  end

  // Checks
  property p_pwr_drive;
    @(posedge mclk) disable iff (rst)
      (straps_valid && pwr_sel) |=> (gp_pin_oe[1] && gp_pin_out[1] == $past(power_override_value));
  endproperty
  a_pwr_drive: assert property (p_pwr_drive) else $error("pin one not override");

  property p_clock_stop_request_input;
    @(posedge mclk) disable iff (rst)
      straps.clock_stop_en |=> !gp_pin_oe[0];
  endproperty
  a_clock_stop_request_input: assert property (p_clock_stop_request_input) else $error("pin zero driven");

  property p_gpio_dir;
    @(posedge mclk) disable iff (rst)
      straps_valid |=> (gp_pin_oe[3] == $past(gp_direction[3]));
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("pin three direction");

  property p_hold;
    @(posedge mclk) disable iff (rst)
      (straps_valid && $past(straps_valid)) |-> $stable(straps);
  endproperty
  a_hold: assert property (p_hold) else $error("straps changed");

  property p_clk_en;
    @(posedge mclk) disable iff (rst)
      1'b1 |=> (clock_stop_enabled == $past(straps.clock_stop_en));
  endproperty
  a_clk_en: assert property (p_clk_en) else $error("clock stop status");

  property p_arb;
    @(posedge mclk) disable iff (rst)
      !straps.outside_arbiter |=> (gnt_zero_out && !arb_grant_core);
  endproperty
  a_arb: assert property (p_arb) else $error("arbiter pins active");

  property p_ext_req;
    @(posedge mclk) disable iff (rst)
      (straps.outside_arbiter && arb_request_core) |=> !gnt_zero_out;
  endproperty
  a_ext_req: assert property (p_ext_req) else $error("request not driven");

  property p_sda;
    @(posedge mclk) disable iff (rst)
      (straps_valid && !straps.serial_bus_mode) |=> (gp_pin_oe[5] == $past(gp_direction[5]));
  endproperty
  a_sda: assert property (p_sda) else $error("pin five direction");

  property p_scl;
    @(posedge mclk) disable iff (rst)
      (straps.serial_bus_mode) |=> (gp_pin_out[4] == 1'b0);
  endproperty
  a_scl: assert property (p_scl) else $error("serial clock high drive");

endmodule

// file: test/mpf_board_model.sv
/*
  Board model: strap resistors and devices attached to the shared pins.
  Assumes pad enables are high while the bridge drives a pin.
*/
`timescale 1ns/1ns
module mpf_board_model
  import mpf_pkg::*;
(
  // Board setup from the bench
  input  wire logic [1:0]            strap_pull,
  input  wire logic [MPF_NUM_GP-1:0] pull_up,
  input  wire logic [MPF_NUM_GP-1:0] dev_en,
  input  wire logic [MPF_NUM_GP-1:0] dev_val,
  // Bridge pads and straps
  input  wire logic [MPF_NUM_GP-1:0] gp_pin_out,
  input  wire logic [MPF_NUM_GP-1:0] gp_pin_oe,
  output logic [MPF_NUM_GP-1:0]      gp_pin_in,
  output logic                       clock_stop_support_strap,
  output logic                       outside_arbiter_strap
);
  // Strap resistors, pulldown unless a pullup is fitted
  assign clock_stop_support_strap = strap_pull[0];
  assign outside_arbiter_strap    = strap_pull[1];
  // Pad level: bridge, else attached device, else resistor; request and clock pulled up
  assign gp_pin_in = (gp_pin_oe & gp_pin_out) | (~gp_pin_oe & dev_en & dev_val)
                   | (~gp_pin_oe & ~dev_en & pull_up);
endmodule

// file: test/tb_top.sv
/*
  Testbench for the pin function selector: strap latching, pin routing, arbiter pins.
  Assumes the board model supplies pad levels and strap resistors.
*/
`timescale 1ns/1ns
module tb_top;
  import mpf_pkg::*;
  localparam int N = MPF_NUM_GP;
  logic           mclk, rst, fundamental_reset_n, pov;
  logic [1:0]     strap_pull;
  logic [N-1:0]   pull_up, dev_en, dev_val, gp_direction, gp_out_value;
  logic [N-1:0]   gp_pin_in, gp_pin_out, gp_pin_oe, gp_in_value;
  logic [2:0]     power_override_field;
  logic           power_override_value, serial_clock_oe_core, serial_data_oe_core;
  logic           arb_request_core, req_zero_in, gnt_zero_out;
  logic           clock_stop_support_strap, outside_arbiter_strap;
  logic           clock_stop_enabled, outside_arbiter_sel, compat_mode, serial_bus_mode;
  logic           clock_stop_request, power_override_active, serial_clock_in;
  logic           serial_data_in, arb_grant_core, m_cs, m_oa, m_ser;
  logic [2*N-1:0] drv;
  int             num_errors = 0;
  int             check_count = 0;
  int             cycles = 0;

  mpf_board_model brd (.strap_pull, .pull_up, .dev_en, .dev_val, .gp_pin_out, .gp_pin_oe,
    .gp_pin_in, .clock_stop_support_strap, .outside_arbiter_strap);
  mpf_pin_select #(.NUM_GP(N)) dut (.mclk, .rst, .fundamental_reset_n,
    .clock_stop_support_strap, .outside_arbiter_strap, .gp_direction, .gp_out_value,
    .power_override_field, .power_override_value, .serial_clock_oe_core,
    .serial_data_oe_core, .arb_request_core, .gp_pin_in, .gp_pin_out, .gp_pin_oe,
    .req_zero_in, .gnt_zero_out, .gp_in_value, .clock_stop_enabled, .outside_arbiter_sel,
    .compat_mode, .serial_bus_mode, .clock_stop_request, .power_override_active,
    .serial_clock_in, .serial_data_in, .arb_grant_core);

  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end

  // Comparisons and verdict
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [N-1:0] got, input logic [N-1:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Expected pad enables and driven values, packed as {oe, out}
  function automatic logic [2*N-1:0] exp_drive(input logic cs, input logic ser, input logic po);
    logic [N-1:0] oe;
    logic [N-1:0] out;
    oe = gp_direction;
    out = gp_out_value;
    if (cs) begin
      oe[0] = 1'b0;
    end
    if (po) begin
      oe[1] = 1'b1;
      out[1] = power_override_value;
    end
    if (ser) begin
      oe[5:4] = {serial_data_oe_core, serial_clock_oe_core};
      out[5:4] = 2'h0;
    end
    return {oe, out & oe};
  endfunction

  // Fundamental reset with a board setup {pin5 pull, pin2 pull, arbiter, clock run}
  task automatic start_mode(input logic [3:0] c);
    fundamental_reset_n = 1'b0;
    strap_pull = c[1:0];
    pull_up = {c[3], 1'b1, 1'b1, c[2], 1'b1, 1'b1};
    dev_en = '0;
    gp_direction = '1;
    repeat (2) @(negedge mclk);
    chk_vec(gp_pin_oe, '0);
    fundamental_reset_n = 1'b1;
    repeat (6) @(negedge mclk);
    {m_ser, m_oa, m_cs} = {c[3], c[1:0]};
    strap_pull = ~c[1:0];
    pull_up[2] = ~c[2];
    pull_up[5] = ~c[3];
    repeat (2) @(negedge mclk);
    chk_bit(clock_stop_enabled, c[0]);
    chk_bit(outside_arbiter_sel, c[1]);
    chk_bit(compat_mode, c[2]);
    chk_bit(serial_bus_mode, c[3]);
  endtask

  // One random pin setup with a chosen override code
  task automatic step(input logic [2:0] fld);
    gp_direction = N'($urandom);
    gp_out_value = N'($urandom);
    dev_en = N'($urandom);
    dev_val = N'($urandom);
    {power_override_value, serial_clock_oe_core, serial_data_oe_core} = 3'($urandom);
    {arb_request_core, req_zero_in} = 2'($urandom);
    power_override_field = fld;
    pov = (fld == MPF_PWR_CODE_A) || (fld == MPF_PWR_CODE_B);
    drv = exp_drive(m_cs, m_ser, pov);
    repeat (2) @(negedge mclk);
    chk_vec(gp_pin_oe, drv[2*N-1:N]);
    chk_vec(gp_pin_out & gp_pin_oe, drv[N-1:0]);
    chk_bit(power_override_active, pov);
    chk_vec(gp_in_value, gp_pin_in);
    chk_bit(clock_stop_request, m_cs & gp_pin_in[0]);
    chk_bit(serial_clock_in, m_ser ? gp_pin_in[4] : 1'b1);
    chk_bit(serial_data_in, m_ser ? gp_pin_in[5] : 1'b1);
    chk_bit(gnt_zero_out, m_oa ? ~arb_request_core : 1'b1);
    chk_bit(arb_grant_core, m_oa & ~req_zero_in);
  endtask

  // Main sequence: every board setup, every override code, then a random setup
  initial begin
    void'($urandom(32'h7654DAEC));
    {rst, fundamental_reset_n, strap_pull, pull_up, dev_en, dev_val} = {1'b1, 1'b0, 2'h0,
      6'h3F, 6'h00, 6'h00};
    {gp_direction, gp_out_value, power_override_field} = '0;
    {power_override_value, serial_clock_oe_core, serial_data_oe_core} = 3'h0;
    {arb_request_core, req_zero_in, m_cs, m_oa, m_ser} = 5'h00;
    repeat (4) @(negedge mclk);
    chk_bit(gnt_zero_out, 1'b1);
    chk_bit(serial_data_in, 1'b1);
    rst = 1'b0;
    for (int c = 0; c < 16; c++) begin
      start_mode(4'(c));
      for (int k = 0; k < 8; k++) begin
        step(3'(k));
      end
    end
    start_mode(4'($urandom));
    repeat (8) step(3'($urandom));
    tally_and_finish();
  end
endmodule
